// File: pkg/acl_pkg.sv
package acl_pkg;

  localparam int N_ENT  = 16;
  localparam int IDX_W  = 4;
  localparam int N_PORT = 7;
  localparam int CNT_W  = 11;
  localparam int PRI_W  = 3;
  localparam int ADR_W  = 10;

  // register byte addresses
  localparam logic [ADR_W-1:0] INT_STAT_ADR = 10'h000;
  localparam logic [ADR_W-1:0] INT_MASK_ADR = 10'h004;
  localparam logic [ADR_W-1:0] GLB_STAT_ADR = 10'h008;
  localparam logic [ADR_W-1:0] GLB_MASK_ADR = 10'h00c;
  localparam logic [1:0]       TBL_PAGE     = 2'h1;
  localparam int               TBL_PG_LSB   = 8;
  localparam int               TBL_IX_LSB   = 4;
  localparam int               TBL_WD_LSB   = 2;

  // word within a table entry
  localparam logic [1:0] W_CTL   = 2'h0;
  localparam logic [1:0] W_MACLO = 2'h1;
  localparam logic [1:0] W_MACHI = 2'h2;
  localparam logic [1:0] W_ACT   = 2'h3;

  // control word fields
  localparam int MODE_LSB  = 0;
  localparam int SUB_LSB   = 2;
  localparam int SD_BIT    = 4;
  localparam int ETYPE_LSB = 16;
  // action word fields; CNT_RD_LSB is the count field of a W_MACHI read
  localparam int COUNT_LSB = 0;
  localparam int PM_LSB    = 0;
  localparam int P_LSB     = 2;
  localparam int RPE_BIT   = 5;
  localparam int RP_LSB    = 6;
  localparam int MM_LSB    = 9;
  localparam int TU_BIT    = 11;
  localparam int CA_BIT    = 12;
  localparam int FWD_LSB   = 16;
  localparam int CNT_RD_LSB = 16;

  localparam logic [31:0] CTL_MASK   = 32'hffff_001f;
  localparam logic [31:0] MACHI_MASK = 32'h0000_ffff;
  localparam logic [31:0] ACT_MASK   = 32'h007f_1fff;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;

  localparam logic [1:0] MODE_COUNT = 2'b01;
  localparam logic [1:0] SUB_COUNT  = 2'b00;

  typedef enum logic [1:0] {
    PM_QOS   = 2'b00,
    PM_RAISE = 2'b01,
    PM_LOWER = 2'b10,
    PM_FORCE = 2'b11
  } pm_t;

  typedef enum logic [1:0] {
    MM_KEEP    = 2'b00,
    MM_OR      = 2'b01,
    MM_AND     = 2'b10,
    MM_REPLACE = 2'b11
  } mm_t;

  // tick timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
  localparam int US_CW         = $clog2(US_CYC);
  localparam int MS_US         = 1000;
  localparam int MS_CW         = $clog2(MS_US);

  typedef struct packed {
    logic              valid;
    logic              hit;
    logic [IDX_W-1:0]  idx;
    logic [PRI_W-1:0]  qos_prio;
    logic [PRI_W-1:0]  pcp;
    logic [N_PORT-1:0] lookup_map;
    logic [47:0]       da;
    logic [47:0]       sa;
    logic [15:0]       etype;
  } frame_in_t;

  typedef struct packed {
    logic              valid;
    logic [PRI_W-1:0]  prio;
    logic              remarked;
    logic [PRI_W-1:0]  pcp;
    logic [N_PORT-1:0] fwd_map;
  } action_out_t;

endpackage : acl_pkg

// File: logic/acl_action_and_count.sv
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
// Operation
// - priority mode 00 keeps the quality-of-service priority untouched.
// - mode 01 takes rule priority only when above quality-of-service value.
// - mode 10 takes rule priority only when below quality-of-service value.
// - mode 11 always takes the rule priority.
// - remark enable set replaces tag PCP with the remarked priority.
// - map mode 01 ORs rule mask into lookup map; 00 keeps it.
// - map mode 10 ANDs rule mask with the lookup map.
// - map mode 11 replaces lookup map with the rule mask.
// - mask bit n stands for switch port n+1; one means forward.
// - algorithm 0 loads 11-bit down-counter, ticks down, interrupts on expiry.
// - tick unit select 0 gives microseconds, 1 gives milliseconds.
// - algorithm 1 counts matched frames, interrupts at terminal count.
// - frame counter restarts from zero after its interrupt.
// - each port table holds 16 entries of matching, action, process.
// - fields act alone except count mode, mode 01 subselect 00.
// - filtering never raises interrupts; only count-mode entries do.
// - per-port count interrupt with readable, write-one-to-clear status and a settable mask.
// - port interrupt feeds global status bit gated by global mask.
// - count value is the priority, remark and map mode bit span.
// - frame qualifies only when MAC address and EtherType both match.
module acl_action_and_count (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [acl_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // frame from classification and lookup
  input  wire acl_pkg::frame_in_t          frame_i,
  // result towards queueing and forwarding
  output acl_pkg::action_out_t             action_o,
  // global port interrupt
  output logic                             irq_o
);

  localparam int NE = acl_pkg::N_ENT;
  localparam int CW = acl_pkg::CNT_W;
  localparam int PW = acl_pkg::PRI_W;
  localparam int NP = acl_pkg::N_PORT;

  // entry storage
  logic [31:0]         ctl_q   [NE];
  logic [31:0]         maclo_q [NE];
  logic [31:0]         machi_q [NE];
  logic [31:0]         act_q   [NE];
  logic [CW-1:0]       cnt_q   [NE];
  logic                armed_q [NE];
  logic                ev_q    [NE];
  logic                ld_q    [NE];
  logic [NE-1:0]       ev_vec;

  logic                ack_q;
  logic [31:0]         dat_q;
  logic [31:0]         rd_d;
  logic [NE-1:0]       int_stat_q;
  logic [NE-1:0]       int_stat_d;
  logic                port_mask_q;
  logic                glb_mask_q;
  logic                port_irq;
  logic                irq_q;
  acl_pkg::action_out_t act_out_q;
  acl_pkg::action_out_t act_out_d;

  logic [acl_pkg::US_CW-1:0] us_cnt_q;
  logic [acl_pkg::MS_CW-1:0] ms_cnt_q;
  logic                      us_tick_q;
  logic                      ms_tick_q;

  logic                bus_req;
  logic                wr;
  logic                tbl_sel;
  logic [acl_pkg::IDX_W-1:0] tbl_idx;
  logic [1:0]          tbl_wd;
  logic [acl_pkg::ADR_W-1:0] reg_adr;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr      = bus_req & wb_we_i;
  assign tbl_sel = wb_adr_i[acl_pkg::TBL_PG_LSB +: 2] == acl_pkg::TBL_PAGE;
  assign tbl_idx = wb_adr_i[acl_pkg::TBL_IX_LSB +: acl_pkg::IDX_W];
  assign tbl_wd  = wb_adr_i[acl_pkg::TBL_WD_LSB +: 2];
  // low address bits take no part in control register decode
  assign reg_adr = {wb_adr_i[acl_pkg::ADR_W-1:acl_pkg::TBL_WD_LSB],
                    acl_pkg::TBL_WD_LSB'(0)};

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign action_o = act_out_q;
  assign irq_o    = irq_q;

  // byte-lane merge; bits outside the field mask read zero except the count field of a W_MACHI read
  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  sel,
    input logic [31:0] keep
  );
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r & keep;
  endfunction : merge

  // bus handshake: ack one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_d = acl_pkg::WORD_RST;
    if (tbl_sel) begin
      case (tbl_wd)
        acl_pkg::W_CTL:   rd_d = ctl_q[tbl_idx];
        acl_pkg::W_MACLO: rd_d = maclo_q[tbl_idx];
        acl_pkg::W_MACHI: begin
          rd_d = machi_q[tbl_idx];
          rd_d[acl_pkg::CNT_RD_LSB +: CW] = cnt_q[tbl_idx];
        end
        default:          rd_d = act_q[tbl_idx];
      endcase
    end else begin
      case (reg_adr)
        acl_pkg::INT_STAT_ADR: rd_d[NE-1:0] = int_stat_q;
        acl_pkg::INT_MASK_ADR: rd_d[0] = port_mask_q;
        acl_pkg::GLB_STAT_ADR: rd_d[0] = port_irq;
        acl_pkg::GLB_MASK_ADR: rd_d[0] = glb_mask_q;
        default:               rd_d = acl_pkg::WORD_RST;
      endcase
    end
  end

  // read data stands only in the ack cycle, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dat_q <= acl_pkg::WORD_RST;
    end else if (bus_req && !wb_we_i) begin
      dat_q <= rd_d;
    end else begin
      dat_q <= acl_pkg::WORD_RST;
    end
  end

  // table writes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NE; i++) begin
        ctl_q[i]   <= acl_pkg::WORD_RST;
        maclo_q[i] <= acl_pkg::WORD_RST;
        machi_q[i] <= acl_pkg::WORD_RST;
        act_q[i]   <= acl_pkg::WORD_RST;
      end
    end else if (wr && tbl_sel) begin
      case (tbl_wd)
        acl_pkg::W_CTL: ctl_q[tbl_idx] <= merge(ctl_q[tbl_idx],
          wb_dat_i, wb_sel_i, acl_pkg::CTL_MASK);
        acl_pkg::W_MACLO: maclo_q[tbl_idx] <= merge(maclo_q[tbl_idx],
          wb_dat_i, wb_sel_i, '1);
        acl_pkg::W_MACHI: machi_q[tbl_idx] <= merge(machi_q[tbl_idx],
          wb_dat_i, wb_sel_i, acl_pkg::MACHI_MASK);
        default: act_q[tbl_idx] <= merge(act_q[tbl_idx],
          wb_dat_i, wb_sel_i, acl_pkg::ACT_MASK);
      endcase
    end
  end

  // interrupt registers, set wins over clear
  always_comb begin
    int_stat_d = int_stat_q | ev_vec;
    if (wr && !tbl_sel && reg_adr == acl_pkg::INT_STAT_ADR) begin
      int_stat_d = (int_stat_q & ~(wb_dat_i[NE-1:0] & {
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})) | ev_vec;
    end
  end

  // global status: any entry event, gated by the port mask
  assign port_irq = (|int_stat_q) & port_mask_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      int_stat_q  <= '0;
      port_mask_q <= 1'b0;
      glb_mask_q  <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      if (wr && !tbl_sel && wb_sel_i[0]) begin
        if (reg_adr == acl_pkg::INT_MASK_ADR) begin
          port_mask_q <= wb_dat_i[0];
        end
        if (reg_adr == acl_pkg::GLB_MASK_ADR) begin
          glb_mask_q <= wb_dat_i[0];
        end
      end
      // pin follows the global status gated by the global mask, one cycle later
      irq_q <= port_irq & glb_mask_q;
    end
  end

  // microsecond and millisecond tick enables
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      us_cnt_q  <= '0;
      us_tick_q <= 1'b0;
    end else if (us_cnt_q == acl_pkg::US_CW'(acl_pkg::US_CYC - 1)) begin
      us_cnt_q  <= '0;
      us_tick_q <= 1'b1;
    end else begin
      us_cnt_q  <= us_cnt_q + 1'b1;
      us_tick_q <= 1'b0;
    end
  end

  // ms tick counts us ticks, both restart together after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ms_cnt_q  <= '0;
      ms_tick_q <= 1'b0;
    end else if (!us_tick_q) begin
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q == acl_pkg::MS_CW'(acl_pkg::MS_US - 1)) begin
      ms_cnt_q  <= '0;
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q  <= ms_cnt_q + 1'b1;
      ms_tick_q <= 1'b0;
    end
  end

  // per-entry count mode logic
  for (genvar g = 0; g < NE; g++) begin : g_ent
    logic          is_cnt;
    logic          qual;
    logic          tick;
    logic [47:0]   mac;
    logic [47:0]   fmac;
    logic [CW-1:0] cval;
    logic          ca;

    assign is_cnt = ctl_q[g][acl_pkg::MODE_LSB +: 2] == acl_pkg::MODE_COUNT
                  && ctl_q[g][acl_pkg::SUB_LSB +: 2] == acl_pkg::SUB_COUNT;
    assign mac  = {machi_q[g][15:0], maclo_q[g]};
    assign fmac = ctl_q[g][acl_pkg::SD_BIT] ? frame_i.sa : frame_i.da;
    assign qual = frame_i.valid && is_cnt && fmac == mac
                && frame_i.etype == ctl_q[g][acl_pkg::ETYPE_LSB +: 16];
    assign cval = act_q[g][acl_pkg::COUNT_LSB +: CW];
    assign ca   = act_q[g][acl_pkg::CA_BIT];
    assign tick = act_q[g][acl_pkg::TU_BIT] ? ms_tick_q : us_tick_q;

    // reload one edge after a ctl or action write, once the word is in
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        ld_q[g] <= 1'b0;
      end else begin
        ld_q[g] <= wr && tbl_sel && tbl_idx == acl_pkg::IDX_W'(g)
                   && (tbl_wd == acl_pkg::W_CTL || tbl_wd == acl_pkg::W_ACT);
      end
    end

    // a reload beats frames and ticks; leaving count mode parks it
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        cnt_q[g]   <= '0;
        armed_q[g] <= 1'b0;
        ev_q[g]    <= 1'b0;
      end else begin
        ev_q[g] <= 1'b0;
        if (!is_cnt) begin
          cnt_q[g]   <= '0;
          armed_q[g] <= 1'b0;
        end else if (ld_q[g]) begin
          cnt_q[g]   <= ca ? '0 : cval;
          armed_q[g] <= ~ca;
        end else if (!ca) begin
          if (qual) begin
            cnt_q[g]   <= cval;
            armed_q[g] <= 1'b1;
          end else if (tick && armed_q[g]) begin
            // a value of 0 or 1 expires on the first tick
            if (cnt_q[g] <= CW'(1)) begin
              cnt_q[g]   <= '0;
              armed_q[g] <= 1'b0;
              ev_q[g]    <= 1'b1;
            end else begin
              cnt_q[g] <= cnt_q[g] - 1'b1;
            end
          end
        end else if (qual) begin
          // 11-bit wrap: a value of 0 means 2048 frames
          if (cnt_q[g] + 1'b1 == cval) begin
            cnt_q[g] <= '0;
            ev_q[g]  <= 1'b1;
          end else begin
            cnt_q[g] <= cnt_q[g] + 1'b1;
          end
        end
      end
    end

    assign ev_vec[g] = ev_q[g];
  end

  // action path for the entry the classifier selected
  always_comb begin
    logic [31:0]      a;
    logic [31:0]      c;
    logic [PW-1:0]    p;
    logic [NP-1:0]    fwd;
    logic             apply;
    a     = act_q[frame_i.idx];
    c     = ctl_q[frame_i.idx];
    p     = a[acl_pkg::P_LSB +: PW];
    fwd   = a[acl_pkg::FWD_LSB +: NP];
    // count-mode entries hold a count value, not an action
    apply = frame_i.hit && !(c[acl_pkg::MODE_LSB +: 2] == acl_pkg::MODE_COUNT
            && c[acl_pkg::SUB_LSB +: 2] == acl_pkg::SUB_COUNT);
    act_out_d.valid    = frame_i.valid;
    act_out_d.prio     = frame_i.qos_prio;
    act_out_d.remarked = 1'b0;
    act_out_d.pcp      = frame_i.pcp;
    act_out_d.fwd_map  = frame_i.lookup_map;
    if (apply) begin
      case (acl_pkg::pm_t'(a[acl_pkg::PM_LSB +: 2]))
        acl_pkg::PM_RAISE: begin
          if (p > frame_i.qos_prio) begin
            act_out_d.prio = p;
          end
        end
        acl_pkg::PM_LOWER: begin
          if (p < frame_i.qos_prio) begin
            act_out_d.prio = p;
          end
        end
        acl_pkg::PM_FORCE: act_out_d.prio = p;
        default:           act_out_d.prio = frame_i.qos_prio;
      endcase
      if (a[acl_pkg::RPE_BIT]) begin
        act_out_d.remarked = 1'b1;
        act_out_d.pcp      = a[acl_pkg::RP_LSB +: PW];
      end
      // map bit n is switch port n+1 on both sides
      case (acl_pkg::mm_t'(a[acl_pkg::MM_LSB +: 2]))
        acl_pkg::MM_OR: begin
          act_out_d.fwd_map = frame_i.lookup_map | fwd;
        end
        acl_pkg::MM_AND: begin
          act_out_d.fwd_map = frame_i.lookup_map & fwd;
        end
        acl_pkg::MM_REPLACE: act_out_d.fwd_map = fwd;
        default:             act_out_d.fwd_map = frame_i.lookup_map;
      endcase
    end
  end

  // registered result, one cycle behind the frame
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      act_out_q <= '0;
    end else begin
      act_out_q <= act_out_d;
    end
  end

endmodule : acl_action_and_count

// File: tb/acl_action_and_count_sva.sv
`timescale 1ns/10ps
module acl_chk (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  // register bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // frame path and interrupt
  input wire acl_pkg::frame_in_t   frame_i,
  input wire acl_pkg::action_out_t action_o,
  input wire logic                 irq_o
);
  logic [2:0] quiet_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // cycles since the last bus write, saturating
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      quiet_q <= 3'h0;
    else if (wb_cyc_i && wb_we_i)
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_miss;
    frame_i.valid && !frame_i.hit;
  endsequence
  a_ack_answer: assert property (s_take |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_action_lat: assert property (
    action_o.valid == $past(frame_i.valid))
    else $error("action result not one cycle after frame");
  a_miss_pass: assert property (s_miss |=>
    action_o.prio == $past(frame_i.qos_prio) && !action_o.remarked &&
    action_o.fwd_map == $past(frame_i.lookup_map))
    else $error("unmatched frame altered");
  a_pcp_keep: assert property (
    action_o.valid && !action_o.remarked |->
    action_o.pcp == $past(frame_i.pcp))
    else $error("tag priority changed without remark");
  a_irq_hold: assert property (
    irq_o && quiet_q >= 3'h4 |=> irq_o)
    else $error("interrupt dropped without bus write");
endmodule : acl_chk

bind acl_action_and_count acl_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .frame_i(frame_i), .action_o(action_o),
  .irq_o(irq_o));

// File: tb/acl_far_side.sv
`timescale 1ns/10ps
module acl_far_side #(
  parameter logic [47:0] DA = 48'h0200_0000_0001
) (
  // clock
  input wire logic           sys_clk,
  // frame towards the block
  output acl_pkg::frame_in_t frame_o
);
  acl_pkg::frame_in_t f;
  logic [47:0]        da_v;
  initial frame_o = '0;
  initial da_v = DA;
  // one-cycle frame, then scrambled fields while idle
  task automatic send(input logic hit, input logic [3:0] idx,
                      input logic [2:0] qos, input logic [15:0] ety);
    @(posedge sys_clk);
    f = '0;
    f.valid = 1'b1;
    f.hit = hit;
    f.idx = idx;
    f.qos_prio = qos;
    f.pcp = 3'h2;
    f.lookup_map = 7'h0f;
    f.da = da_v;
    f.sa = ~DA;
    f.etype = ety;
    frame_o <= f;
    @(posedge sys_clk);
    f = ~f;
    f.valid = 1'b0;
    frame_o <= f;
  endtask : send
endmodule : acl_far_side

// File: tb/acl_action_and_count_bench.sv
`timescale 1ns/10ps
module acl_action_and_count_bench;
  typedef struct packed {
    logic [31:0] act;
    logic [2:0]  pri;
    logic        rem;
    logic [2:0]  pcp;
    logic [6:0]  fwd;
  } row_t;
  localparam logic [47:0] DA = 48'h0200_0000_0001;
  // qos 3, pcp 2, lookup map 0f, rule mask 33
  localparam row_t ROWS [6] = '{
    '{32'h0033_001c, 3'h3, 1'h0, 3'h2, 7'h0f},
    '{32'h0033_0215, 3'h5, 1'h0, 3'h2, 7'h3f},
    '{32'h0033_0409, 3'h3, 1'h0, 3'h2, 7'h03},
    '{32'h0033_07a6, 3'h1, 1'h1, 3'h6, 7'h33},
    '{32'h0033_001a, 3'h3, 1'h0, 3'h2, 7'h0f},
    '{32'h0033_0023, 3'h0, 1'h1, 3'h0, 7'h0f}};
  logic                 sys_clk;
  logic                 rstn;
  logic                 cyc;
  logic                 stb;
  logic                 we;
  logic                 ack;
  logic                 irq;
  logic [9:0]           adr;
  logic [3:0]           sel;
  logic [31:0]          wdat;
  logic [31:0]          rdat;
  logic [31:0]          rv;
  acl_pkg::frame_in_t   frm;
  acl_pkg::action_out_t act;
  int                   miscompares;
  int                   num_checks;

  acl_action_and_count dut (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .frame_i(frm), .action_o(act),
    .irq_o(irq));
  acl_far_side #(.DA(DA)) far (.sys_clk(sys_clk), .frame_o(frm));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [9:0] a, input logic [31:0] e,
                    input string nm);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
    check(nm, rv, e);
  endtask : rd

  function automatic logic [9:0] ea(input int i, input logic [1:0] w);
    return {2'h1, 4'(i), w, 2'h0};
  endfunction : ea

  // count-mode entry: mac, action word, then control word
  task automatic wentry(input int i, input logic [31:0] ctl, ac);
    wb(1'b1, ea(i, acl_pkg::W_MACLO), DA[31:0], 4'hf);
    wb(1'b1, ea(i, acl_pkg::W_MACHI), {16'h0000, DA[47:32]}, 4'hf);
    wb(1'b1, ea(i, acl_pkg::W_ACT), ac, 4'hf);
    wb(1'b1, ea(i, acl_pkg::W_CTL), ctl, 4'hf);
  endtask : wentry

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  initial begin
    repeat (45000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = '0;
    wdat = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(acl_pkg::INT_MASK_ADR, 32'h0, "mask reset");
    wb(1'b1, ea(15, acl_pkg::W_ACT), 32'hffff_ffff, 4'hf);
    rd(ea(15, acl_pkg::W_ACT), acl_pkg::ACT_MASK, "entry 15");
    rd(10'h010, 32'h0, "unmapped");
    foreach (ROWS[i]) begin
      wb(1'b1, ea(0, acl_pkg::W_ACT), ROWS[i].act, 4'hf);
      far.send(1'b1, 4'h0, 3'h3, 16'h0800);
      #1;
      check("valid", 32'(act.valid), 32'h1);
      check("prio", 32'(act.prio), 32'(ROWS[i].pri));
      check("remark", 32'(act.remarked), 32'(ROWS[i].rem));
      check("pcp", 32'(act.pcp), 32'(ROWS[i].pcp));
      check("map", 32'(act.fwd_map), 32'(ROWS[i].fwd));
    end
    check("filter irq", 32'(irq), 32'h0);
    rd(acl_pkg::INT_STAT_ADR, 32'h0, "filter status");
    // frame counter of 3 on entry 1
    wb(1'b1, acl_pkg::INT_MASK_ADR, 32'h1, 4'hf);
    wb(1'b1, acl_pkg::GLB_MASK_ADR, 32'h1, 4'hf);
    wentry(1, 32'h88b5_0001, 32'h0000_1003);
    far.send(1'b1, 4'h1, 3'h5, 16'h88b6);
    #1;
    check("count entry", 32'(act.prio), 32'h5);
    repeat (2) far.send(1'b1, 4'h1, 3'h3, 16'h88b5);
    // right type, wrong address: must not count
    far.da_v = {DA[47:1], ~DA[0]};
    far.send(1'b1, 4'h1, 3'h3, 16'h88b5);
    far.da_v = DA;
    far.send(1'b0, 4'h0, 3'h3, 16'h88b6);
    repeat (4) @(posedge sys_clk);
    check("irq early", 32'(irq), 32'h0);
    far.send(1'b1, 4'h1, 3'h3, 16'h88b5);
    repeat (4) @(posedge sys_clk);
    check("irq", 32'(irq), 32'h1);
    rd(acl_pkg::INT_STAT_ADR, 32'h2, "status");
    rd(ea(1, acl_pkg::W_MACHI), {16'h0, DA[47:32]}, "cnt");
    wb(1'b1, acl_pkg::GLB_MASK_ADR, 32'h0, 4'hf);
    repeat (3) @(posedge sys_clk);
    check("irq masked", 32'(irq), 32'h0);
    rd(acl_pkg::GLB_STAT_ADR, 32'h1, "global");
    wb(1'b1, acl_pkg::INT_STAT_ADR, 32'hffff_ffff, 4'h1);
    rd(acl_pkg::INT_STAT_ADR, 32'h0, "cleared");
    // microsecond timeout of 3 on entry 2
    wentry(2, 32'h88b6_0001, 32'h0000_0003);
    repeat (5) begin
      repeat (60) @(posedge sys_clk);
      far.send(1'b1, 4'h2, 3'h3, 16'h88b6);
    end
    rd(acl_pkg::INT_STAT_ADR, 32'h0, "kept alive");
    repeat (70) @(posedge sys_clk);
    rd(acl_pkg::INT_STAT_ADR, 32'h0, "before expiry");
    repeat (60) @(posedge sys_clk);
    rd(acl_pkg::INT_STAT_ADR, 32'h4, "expired");
    // millisecond timeout of 1 on entry 3
    wentry(3, 32'h88b7_0001, 32'h0000_0801);
    repeat (100) @(posedge sys_clk);
    rd(acl_pkg::INT_STAT_ADR, 32'h4, "ms pending");
    repeat (40000) @(posedge sys_clk);
    rd(acl_pkg::INT_STAT_ADR, 32'hc, "ms expired");
    wb(1'b1, acl_pkg::GLB_MASK_ADR, 32'h1, 4'hf);
    repeat (2) @(posedge sys_clk);
    check("irq before reset", 32'(irq), 32'h1);
    // second reset in mid-run
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(acl_pkg::INT_STAT_ADR, 32'h0, "status reset");
    check("irq reset", 32'(irq), 32'h0);
    rd(ea(15, acl_pkg::W_ACT), 32'h0, "table reset");
    rd(acl_pkg::GLB_MASK_ADR, 32'h0, "global mask reset");
    stop_test();
  end
endmodule : acl_action_and_count_bench
